// ---- core/psq_core.sv ----
// Operation
// - pc advances by one per instruction
// - bank select bit forms top address bit
// - only pc low byte is software visible
// - jumps, calls, interrupts, reset load pc
// - taken skip discards prefetch, dummy cycle
// - pc low write jumps in page, dummy
// - sixteen level stack, software cannot reach
// - call and interrupt acknowledge push pc
// - returns restore pc from latest entry
// - reset points stack pointer at top
// - full stack holds interrupt until return
// - call on full stack overwrites oldest
// - alu updates status and destination register
// - alu op set, normal and extended forms
// - 16k by 16 program memory, two pointers
// - execution starts at address zero
// - table read: low to memory, high latched
// - normal sector zero, extended any sector
// - table instructions take two cycles
// - table high latch readable and writable
// - four phases per instruction cycle
// - eight bit alu through accumulator
`timescale 1ns/1ps
`default_nettype none

module psq_core #(
    parameter int DMEM_DEPTH = 64,
    parameter int SECTOR_SIZE = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // program memory port
    output logic [13:0] pm_addr,
    output logic pm_rd,
    input wire logic [15:0] pm_rdata,
    // interrupt request and status
    input wire logic irq_req,
    output logic irq_ack,
    output logic dummy_cycle,
    output logic stack_full
);

    localparam int DM_AW = $clog2(DMEM_DEPTH);
    localparam int SEC_AW = $clog2(SECTOR_SIZE);

    psq_pkg::psq_phase_t phase_reg;
    logic [13:0] pc_reg, pc_next, pm_addr_next, flow_tgt;
    logic [15:0] fetch_reg;
    psq_pkg::psq_instr_t ir_reg;
    logic ir_valid_reg, ir_valid_next, tbl_cycle_reg;
    logic [DM_AW-1:0] tbl_idx_reg;
    localparam int STACK_LEVELS_M1 = psq_pkg::STACK_LEVELS - 1;
    logic [13:0] stack_mem [STACK_LEVELS_M1:0];
    logic [3:0] sp_reg;
    logic [4:0] depth_reg;
    logic [7:0] acc_reg, tab_ptr_lo_reg, tab_ptr_hi_reg, table_high_latch;
    logic [7:0] dmem [DMEM_DEPTH];
    psq_pkg::psq_status_t st_reg, st_d;
    logic halt_reg, ien_reg, irq_pend_reg, code_bank_select_bit;
    logic pc_low_byte_pend, pm_rd_reg, irq_ack_reg, dummy_reg, full_reg;
    logic [7:0] pc_low_byte_val;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;

    // decoded step controls
    logic step, exec, flow, push, pop, tbl_start, ack, sw_jump, set_ien;
    logic acc_we, st_we, dm_we;
    logic [7:0] acc_d, dm_d, m, v;
    logic [DM_AW-1:0] dm_idx;
    logic [8:0] sum;
    logic full;
    logic bus_wr, setup, hit;

    assign step = (phase_reg == psq_pkg::PH_T4) && !halt_reg;
    assign exec = step && ir_valid_reg && !tbl_cycle_reg;
    assign full = (depth_reg == 5'(psq_pkg::STACK_LEVELS));

    // normal forms reach sector zero only, extended and far forms the whole array
    always_comb begin
        if (ir_reg.arg[psq_pkg::ARG_EXT_BIT] || ir_reg.cls == psq_pkg::CLS_FAR_ALU) begin
            dm_idx = ir_reg.arg[DM_AW-1:0];
        end else begin
            dm_idx = DM_AW'(ir_reg.arg[SEC_AW-1:0]);
        end
    end

    assign m = dmem[dm_idx];

    // execute stage: one decision per instruction cycle, at the close of T4
    always_comb begin
        flow = 1'b0;
        flow_tgt = pc_reg;
        push = 1'b0;
        pop = 1'b0;
        tbl_start = 1'b0;
        set_ien = 1'b0;
        acc_we = 1'b0;
        acc_d = acc_reg;
        st_we = 1'b0;
        st_d = st_reg;
        dm_we = 1'b0;
        dm_d = acc_reg;
        sum = 9'h000;
        v = m;
        if (exec) begin
            unique case (ir_reg.cls)
                psq_pkg::CLS_ALU, psq_pkg::CLS_FAR_ALU: begin
                    st_we = 1'b1;
                    unique case (psq_pkg::psq_alu_op_t'(ir_reg.arg[11:8]))
                        psq_pkg::ALU_ADD, psq_pkg::ALU_ADC: begin
                            sum = {1'b0, acc_reg} + {1'b0, m}
                                + {8'h00, ir_reg.arg[8] & st_reg.c};
                            v = sum[7:0];
                            st_d.c = sum[8];
                            st_d.ac = (acc_reg[3:0] + m[3:0]) > 5'h0F;
                            st_d.ov = (acc_reg[7] == m[7]) && (v[7] != m[7]);
                        end
                        psq_pkg::ALU_SUB, psq_pkg::ALU_SBC: begin
                            sum = {1'b0, acc_reg} - {1'b0, m}
                                - {8'h00, ir_reg.arg[8] & ~st_reg.c};
                            v = sum[7:0];
                            st_d.c = ~sum[8]; // carry set means no borrow
                            st_d.ac = acc_reg[3:0] >= m[3:0];
                            st_d.ov = (acc_reg[7] != m[7]) && (v[7] != acc_reg[7]);
                        end
                        psq_pkg::ALU_AND: v = acc_reg & m;
                        psq_pkg::ALU_OR: v = acc_reg | m;
                        psq_pkg::ALU_XOR: v = acc_reg ^ m;
                        psq_pkg::ALU_CPL: v = ~m;
                        psq_pkg::ALU_RR: v = {m[0], m[7:1]};
                        psq_pkg::ALU_RL: v = {m[6:0], m[7]};
                        psq_pkg::ALU_RRC: begin
                            v = {st_reg.c, m[7:1]};
                            st_d.c = m[0];
                        end
                        psq_pkg::ALU_RLC: begin
                            v = {m[6:0], st_reg.c};
                            st_d.c = m[7];
                        end
                        psq_pkg::ALU_INC: v = m + 8'h01;
                        psq_pkg::ALU_DEC: v = m - 8'h01;
                        psq_pkg::ALU_DEC_ADJ: begin
                            sum = {1'b0, acc_reg};
                            if (acc_reg[3:0] > 4'h9 || st_reg.ac) begin
                                sum = sum + 9'h006;
                            end
                            if (sum[7:4] > 4'h9 || st_reg.c || sum[8]) begin
                                sum = sum + 9'h060;
                            end
                            v = sum[7:0];
                            st_d.c = st_reg.c | sum[8];
                        end
                        psq_pkg::ALU_MOV: v = ir_reg.arg[psq_pkg::ARG_DEST_MEM_BIT] ? acc_reg : m;
                    endcase
                    // zero flag follows every result except rotates and moves
                    if (ir_reg.arg[11:10] != 2'b10 && ir_reg.arg[11:8] != 4'hF) begin
                        st_d.z = (v == 8'h00);
                    end
                    if (ir_reg.arg[psq_pkg::ARG_DEST_MEM_BIT]) begin
                        dm_we = 1'b1;
                        dm_d = v;
                    end else begin
                        acc_we = 1'b1;
                        acc_d = v;
                    end
                end
                psq_pkg::CLS_BRANCH, psq_pkg::CLS_CALL: begin
                    flow = 1'b1;
                    flow_tgt = {code_bank_select_bit, ir_reg.arg};
                    push = (ir_reg.cls == psq_pkg::CLS_CALL);
                end
                psq_pkg::CLS_SKIP: begin
                    unique case (psq_pkg::psq_skip_t'(ir_reg.arg[9:8]))
                        psq_pkg::SK_INC_ZERO: v = m + 8'h01;
                        psq_pkg::SK_DEC_ZERO: v = m - 8'h01;
                        default: v = m;
                    endcase
                    if (ir_reg.arg[psq_pkg::ARG_TO_ACC_BIT]) begin
                        acc_we = 1'b1;
                        acc_d = v;
                    end else if (ir_reg.arg[9]) begin
                        dm_we = 1'b1;
                        dm_d = v;
                    end
                    // taken skip drops the prefetched word
                    flow = (ir_reg.arg[9:8] == 2'b01) ? (v != 8'h00) : (v == 8'h00);
                    flow_tgt = pc_reg + 14'h0001;
                end
                psq_pkg::CLS_TABLE: tbl_start = 1'b1;
                psq_pkg::CLS_MISC: begin
                    unique case (psq_pkg::psq_misc_t'(ir_reg.arg[9:8]))
                        psq_pkg::MI_SUB_BACK, psq_pkg::MI_INT_BACK: begin
                            flow = 1'b1;
                            pop = 1'b1;
                            flow_tgt = stack_mem[sp_reg - 4'h1];
                            set_ien = ir_reg.arg[8];
                        end
                        psq_pkg::MI_ACC_TO_PC_LOW: begin
                            flow = 1'b1;
                            flow_tgt = {pc_reg[13:8], acc_reg};
                        end
                        psq_pkg::MI_IDLE: flow = 1'b0;
                    endcase
                end
                psq_pkg::CLS_NOP: flow = 1'b0;
            endcase
        end
    end

    // a bus write to the low byte jumps within the page once the core is free
    assign sw_jump = step && !tbl_cycle_reg && !flow && !tbl_start && pc_low_byte_pend;

    // a full stack withholds acknowledge until a return frees a level
    assign ack = step && !tbl_cycle_reg && !flow && !tbl_start && !sw_jump
        && irq_pend_reg && ien_reg && !full;

    // next fetch address; any flow change costs one dummy cycle
    always_comb begin
        ir_valid_next = 1'b1;
        pc_next = pc_reg + 14'h0001;
        pm_addr_next = pc_next;
        if (tbl_cycle_reg) begin
            pc_next = pc_reg;
            pm_addr_next = pc_reg;
            ir_valid_next = ir_valid_reg;
        end else if (tbl_start) begin
            // second cycle fetches the table word, held word runs after it
            pm_addr_next = ir_reg.arg[psq_pkg::ARG_LAST_PAGE_BIT]
                ? {psq_pkg::LAST_PAGE, tab_ptr_lo_reg}
                : {tab_ptr_hi_reg[5:0], tab_ptr_lo_reg};
        end else if (flow || sw_jump || ack) begin
            ir_valid_next = 1'b0;
            if (ack) begin
                pc_next = psq_pkg::INT_VECTOR;
            end else if (sw_jump) begin
                pc_next = {pc_reg[13:8], pc_low_byte_val};
            end else begin
                pc_next = flow_tgt;
            end
            pm_addr_next = pc_next;
        end
    end

    // instruction phase counter, frozen while halted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= psq_pkg::PH_T1;
        end else if (!halt_reg) begin
            phase_reg <= psq_pkg::psq_phase_t'(phase_reg + 2'd1);
        end
    end

    // fetch pipeline: word captured at T3, issued into execute at T4
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= psq_pkg::RESET_VECTOR;
            pm_addr <= psq_pkg::RESET_VECTOR;
            pm_rd_reg <= 1'b1;
            fetch_reg <= psq_pkg::WORD_RST;
            ir_reg <= psq_pkg::WORD_RST;
            ir_valid_reg <= 1'b0;
            tbl_cycle_reg <= 1'b0;
            tbl_idx_reg <= '0;
            dummy_reg <= 1'b1;
        end else begin
            pm_rd_reg <= step;
            if (phase_reg == psq_pkg::PH_T3 && !halt_reg) begin
                fetch_reg <= pm_rdata;
            end
            if (step) begin
                pc_reg <= pc_next;
                pm_addr <= pm_addr_next;
                ir_valid_reg <= ir_valid_next;
                dummy_reg <= !ir_valid_next;
                tbl_cycle_reg <= tbl_start;
                if (!tbl_cycle_reg) begin
                    ir_reg <= fetch_reg;
                end
                if (tbl_start) begin
                    tbl_idx_reg <= dm_idx;
                end
            end
        end
    end

    // return stack: circular, so an overflowing call overwrites the oldest entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_reg <= 4'h0;
            depth_reg <= 5'h00;
            full_reg <= 1'b0;
        end else if (push || ack) begin
            sp_reg <= sp_reg + 4'h1;
            depth_reg <= full ? depth_reg : depth_reg + 5'h01;
            full_reg <= (depth_reg >= 5'(psq_pkg::STACK_LEVELS - 1));
        end else if (pop) begin
            sp_reg <= sp_reg - 4'h1;
            depth_reg <= (depth_reg == 5'h00) ? 5'h00 : depth_reg - 5'h01;
            full_reg <= 1'b0;
        end
    end

    // stack storage has no reset and no bus path
    always_ff @(posedge pclk) begin
        if (push || ack) begin
            stack_mem[sp_reg] <= pc_reg;
        end
    end

    // accumulator, status and table high latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= psq_pkg::BYTE_RST;
            st_reg <= '0;
            table_high_latch <= psq_pkg::BYTE_RST;
        end else begin
            if (acc_we) begin
                acc_reg <= acc_d;
            end
            if (st_we) begin
                st_reg <= st_d;
            end
            // the table read lands after a same-cycle bus write
            if (bus_wr && paddr == psq_pkg::OFS_TAB_HIGH) begin
                table_high_latch <= pwdata[7:0];
            end
            if (step && tbl_cycle_reg) begin
                table_high_latch <= fetch_reg[15:8];
            end
        end
    end

    // data memory: alu results and table low bytes
    always_ff @(posedge pclk) begin
        if (step && tbl_cycle_reg) begin
            dmem[tbl_idx_reg] <= fetch_reg[7:0];
        end else if (dm_we) begin
            dmem[dm_idx] <= dm_d;
        end
    end

    // software visible control: halt, interrupt enable, bank, pointers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_reg <= psq_pkg::CTRL_HALT_RST;
            ien_reg <= psq_pkg::CTRL_IEN_RST;
            code_bank_select_bit <= 1'b0;
            tab_ptr_lo_reg <= psq_pkg::BYTE_RST;
            tab_ptr_hi_reg <= psq_pkg::BYTE_RST;
            irq_pend_reg <= 1'b0;
            irq_ack_reg <= 1'b0;
            pc_low_byte_pend <= 1'b0;
            pc_low_byte_val <= psq_pkg::BYTE_RST;
        end else begin
            irq_ack_reg <= ack;
            if (bus_wr && paddr == psq_pkg::OFS_CTRL) begin
                halt_reg <= pwdata[psq_pkg::CTRL_HALT_BIT];
                ien_reg <= pwdata[psq_pkg::CTRL_IEN_BIT];
            end
            if (ack) begin
                ien_reg <= 1'b0;
            end else if (set_ien) begin
                ien_reg <= 1'b1;
            end
            if (bus_wr && paddr == psq_pkg::OFS_BANK) begin
                code_bank_select_bit <= pwdata[0];
            end
            if (bus_wr && paddr == psq_pkg::OFS_TAB_PTR_LO) begin
                tab_ptr_lo_reg <= pwdata[7:0];
            end
            if (bus_wr && paddr == psq_pkg::OFS_TAB_PTR_HI) begin
                tab_ptr_hi_reg <= pwdata[7:0];
            end
            // a new request in the acknowledge cycle stays pending
            irq_pend_reg <= (irq_pend_reg && !ack) || irq_req
                || (bus_wr && paddr == psq_pkg::OFS_IRQ && pwdata[psq_pkg::IRQ_PEND_BIT]);
            pc_low_byte_pend <= (pc_low_byte_pend && !sw_jump)
                || (bus_wr && paddr == psq_pkg::OFS_PC_LOW);
            if (bus_wr && paddr == psq_pkg::OFS_PC_LOW) begin
                pc_low_byte_val <= pwdata[7:0];
            end
        end
    end

    // bus slave: answer in the first cycle of the access phase
    assign setup = psel && !penable;
    assign bus_wr = psel && penable && pwrite && pready_reg && !pslverr_reg;
    assign hit = paddr inside {psq_pkg::OFS_CTRL, psq_pkg::OFS_IRQ, psq_pkg::OFS_PC_LOW,
        psq_pkg::OFS_TAB_PTR_LO, psq_pkg::OFS_TAB_PTR_HI, psq_pkg::OFS_TAB_HIGH,
        psq_pkg::OFS_ACC, psq_pkg::OFS_STATUS, psq_pkg::OFS_BANK};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !hit;
            if (setup) begin
                unique case (paddr)
                    psq_pkg::OFS_CTRL: prdata_reg <= {30'h0, ien_reg, halt_reg};
                    psq_pkg::OFS_IRQ: prdata_reg <= {31'h0, irq_pend_reg};
                    psq_pkg::OFS_PC_LOW: prdata_reg <= {24'h00_0000, pc_reg[7:0]};
                    psq_pkg::OFS_TAB_PTR_LO: prdata_reg <= {24'h00_0000, tab_ptr_lo_reg};
                    psq_pkg::OFS_TAB_PTR_HI: prdata_reg <= {24'h00_0000, tab_ptr_hi_reg};
                    psq_pkg::OFS_TAB_HIGH: prdata_reg <= {24'h00_0000, table_high_latch};
                    psq_pkg::OFS_ACC: prdata_reg <= {24'h00_0000, acc_reg};
                    psq_pkg::OFS_STATUS: prdata_reg <= {28'h000_0000, st_reg};
                    psq_pkg::OFS_BANK: prdata_reg <= {31'h0, code_bank_select_bit};
                    default: prdata_reg <= 32'h0000_0000; // unmapped reads zero
                endcase
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pm_rd = pm_rd_reg;
    assign irq_ack = irq_ack_reg;
    assign dummy_cycle = dummy_reg;
    assign stack_full = full_reg;

endmodule

`default_nettype wire

// ---- core/psq_pkg.sv ----
package psq_pkg;

    // program counter shape: bank bit, five high bits, low byte
    localparam int PC_W = 14;
    localparam int PC_HIGH_W = 5;
    localparam logic [13:0] RESET_VECTOR = 14'h0000;
    localparam logic [13:0] INT_VECTOR = 14'h0004;
    localparam logic [5:0] LAST_PAGE = 6'h3F;
    localparam int STACK_LEVELS = 16;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IRQ = 8'h04;
    localparam logic [7:0] OFS_PC_LOW = 8'h08;
    localparam logic [7:0] OFS_TAB_PTR_LO = 8'h0C;
    localparam logic [7:0] OFS_TAB_PTR_HI = 8'h10;
    localparam logic [7:0] OFS_TAB_HIGH = 8'h14;
    localparam logic [7:0] OFS_ACC = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_BANK = 8'h20;

    // control and interrupt register fields
    localparam int CTRL_HALT_BIT = 0;
    localparam int CTRL_IEN_BIT = 1;
    localparam int IRQ_PEND_BIT = 0;

    // reset values
    localparam logic CTRL_HALT_RST = 1'b0;
    localparam logic CTRL_IEN_RST = 1'b0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // instruction argument field positions
    localparam int ARG_DEST_MEM_BIT = 12;
    localparam int ARG_EXT_BIT = 11;
    localparam int ARG_TO_ACC_BIT = 10;
    localparam int ARG_LAST_PAGE_BIT = 8;

    typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} psq_phase_t;

    typedef enum logic [2:0] {
        CLS_ALU, CLS_BRANCH, CLS_CALL, CLS_SKIP, CLS_TABLE, CLS_MISC, CLS_FAR_ALU, CLS_NOP
    } psq_cls_t;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR, ALU_CPL,
        ALU_RR, ALU_RL, ALU_RRC, ALU_RLC, ALU_INC, ALU_DEC, ALU_DEC_ADJ, ALU_MOV
    } psq_alu_op_t;

    typedef enum logic [1:0] {SK_ZERO, SK_NONZERO, SK_INC_ZERO, SK_DEC_ZERO} psq_skip_t;

    typedef enum logic [1:0] {MI_SUB_BACK, MI_INT_BACK, MI_ACC_TO_PC_LOW, MI_IDLE} psq_misc_t;

    // one program word: class in the top three bits
    typedef struct packed {
        psq_cls_t cls;
        logic [12:0] arg;
    } psq_instr_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } psq_status_t;

endpackage

// ---- dv/psq_core_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module psq_core_assertions (
    // bus side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // sequencer side
    input wire logic [13:0] pm_addr,
    input wire logic pm_rd,
    input wire logic irq_ack,
    input wire logic dummy_cycle,
    input wire logic stack_full
);
    logic [13:0] jmp_tgt;
    logic bad_addr;
    // target kept at the write, the bus moves on before the jump lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jmp_tgt <= 14'h0000;
        end else if (psel && penable && pready && pwrite && paddr == psq_pkg::OFS_PC_LOW) begin
            jmp_tgt <= {pm_addr[13:8], pwdata[7:0]};
        end
    end
    // anything past the last word or off a word boundary is unmapped
    assign bad_addr = paddr > psq_pkg::OFS_BANK || paddr[1:0] != 2'b00;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_pcl_write; psel && penable && pwrite && paddr == psq_pkg::OFS_PC_LOW; endsequence
    sequence s_next_fetch; !pm_rd [*3] ##1 pm_rd; endsequence
    a_start_zero: assert property ($rose(presetn) |-> pm_rd && pm_addr == 14'h0000)
        else $error("first fetch not at address zero");
    a_four_phase: assert property (pm_rd |=> s_next_fetch)
        else $error("fetch spacing is not four clocks");
    a_addr_hold: assert property (pm_rd |=> $stable(pm_addr) [*3])
        else $error("fetch address moved inside an instruction cycle");
    a_page_jump: assert property (s_pcl_write |-> ##[1:9] (pm_rd && dummy_cycle && pm_addr == jmp_tgt))
        else $error("low byte write did not jump in page with a dummy");
    a_ack_vector: assert property (irq_ack |-> pm_rd && pm_addr == psq_pkg::INT_VECTOR)
        else $error("acknowledge without vector fetch");
    a_full_hold: assert property (irq_ack |-> !$past(stack_full))
        else $error("interrupt taken on a full stack");
    a_stack_reset: assert property ($rose(presetn) |-> !stack_full)
        else $error("stack not empty after reset");
    a_bus_answer: assert property (s_setup |=> pready && pslverr == $past(bad_addr) ##1 !pready)
        else $error("bus answer wrong");
endmodule
bind psq_core psq_core_assertions i_psq_core_assertions (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .pm_addr(pm_addr), .pm_rd(pm_rd), .irq_ack(irq_ack),
    .dummy_cycle(dummy_cycle), .stack_full(stack_full));
`default_nettype wire

// ---- dv/psq_pm_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module psq_pm_model (
    // fetch port
    input wire logic pclk,
    input wire logic [13:0] pm_addr,
    input wire logic pm_rd,
    output logic [15:0] pm_rdata
);
    logic [15:0] mem [0:16383];
    logic rd_d;
    // word is ready one edge before the sampling edge; between reads it churns
    initial begin
        rd_d = 1'b0;
        pm_rdata = 16'h0000;
    end
    always @(posedge pclk) begin
        rd_d <= pm_rd;
        pm_rdata <= rd_d ? mem[pm_addr] : ~pm_rdata;
    end
endmodule
`default_nettype wire

// ---- dv/tb_psq_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb_psq_core;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic irq_req = 1'b0, pready, pslverr, pm_rd, irq_ack, dummy_cycle, stack_full;
    logic [7:0] paddr = 8'h00, v, d;
    logic [31:0] pwdata = 32'h0000_0000, prdata, m;
    logic [13:0] pm_addr, tp, e;
    logic [15:0] pm_rdata, tw;
    logic [32:0] exp_rd[$], r;
    logic [31:0] msk_rd[$];
    logic [13:0] exp_pc[$];
    int miscompares = 0, total_checks = 0, cycles = 0, acks = 0, seed = 98769;
    psq_core i_psq_core (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
        .irq_req(irq_req), .irq_ack(irq_ack), .dummy_cycle(dummy_cycle), .stack_full(stack_full));
    psq_pm_model i_psq_pm_model (.pclk(pclk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata));
    initial forever #2 pclk = ~pclk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // an edge always passes first, so psel is never assigned twice in one step
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] dw,
        input logic [32:0] ex, input logic [31:0] mk);
        @(posedge pclk);
        if (!w) begin exp_rd.push_back(ex); msk_rd.push_back(mk); end
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= dw;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // monitor: each result is matched with the oldest note; also the hang limit
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin miscompares++; print_verdict(); end
        if (presetn && pm_rd && exp_pc.size() > 0) begin
            e = exp_pc.pop_front();
            `CHK(pm_addr, e)
        end
        if (psel && penable && pready && !pwrite) begin
            m = msk_rd.pop_front();
            r = exp_rd.pop_front();
            `CHK({pslverr, prdata & m}, r)
        end
        if (irq_ack === 1'b1) acks++;
    end
    initial begin
        // nops in the first 256 words, then a call, a return, a branch and a table read
        for (int i = 0; i < 256; i++) i_psq_pm_model.mem[i] = 16'hE000;
        i_psq_pm_model.mem[1] = 16'h4010;
        i_psq_pm_model.mem[2] = 16'h2020;
        i_psq_pm_model.mem[16] = 16'hA000;
        i_psq_pm_model.mem[4] = 16'hA100; // vector returns at once
        i_psq_pm_model.mem[32] = 16'h8001;
        tp = {1'b1, 5'($random(seed)), 8'($random(seed))};
        tw = 16'($random(seed));
        i_psq_pm_model.mem[tp] = tw;
        v = {1'b1, 6'($random(seed)), 1'b0};
        i_psq_pm_model.mem[v] = {8'h20, v};
        i_psq_pm_model.mem[{v[7:1], 1'b1}] = {8'h20, v};
        exp_pc = '{0, 1, 2, 16, 17, 2, 3, 32};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        bus(psq_pkg::OFS_TAB_PTR_LO, 1, {24'h0, tp[7:0]}, 0, 0);
        bus(psq_pkg::OFS_TAB_PTR_HI, 1, {26'h0, tp[13:8]}, 0, 0);
        wait (exp_pc.size() == 0);
        repeat (12) @(posedge pclk);
        $display("test fetch order done");
        bus(psq_pkg::OFS_TAB_HIGH, 0, 0, {9'h0, 16'h0, tw[15:8]}, 32'hFFFF_FFFF);
        d = 8'($random(seed));
        bus(psq_pkg::OFS_TAB_HIGH, 1, {24'h0, d}, 0, 0);
        bus(psq_pkg::OFS_TAB_HIGH, 0, 0, {25'h0, d}, 32'hFFFF_FFFF);
        bus(8'h24, 0, 0, {1'b1, 32'h0}, 32'hFFFF_FFFF);
        $display("test table and registers done");
        bus(psq_pkg::OFS_PC_LOW, 1, {24'h0, v}, 0, 0);
        repeat (8) @(posedge pclk);
        bus(psq_pkg::OFS_PC_LOW, 0, 0, {25'h0, v}, 32'h0000_00FE);
        $display("test low byte jump done");
        @(posedge pclk) irq_req <= 1'b1;
        @(posedge pclk) irq_req <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK(acks, 0)
        bus(psq_pkg::OFS_IRQ, 0, 0, 33'h1, 32'h0000_0001);
        bus(psq_pkg::OFS_CTRL, 1, 32'h0000_0002, 0, 0);
        wait (acks == 1);
        repeat (120) @(posedge pclk);
        `CHK(acks, 1)
        bus(psq_pkg::OFS_PC_LOW, 0, 0, {25'h0, v}, 32'h0000_00FE);
        $display("test interrupt done");
        print_verdict();
    end
endmodule
`default_nettype wire
